// ===== logic/sbrg_pkg.sv
// Constants shared by the serial baud rate generator and its helpers.
// Assumes a single clock (the crystal clock) and an APB3 register port.
package sbrg_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] SBRG_CTRL_IDX = 8'h19;
  localparam logic [7:0] SBRG_CTRL_ADDR = {SBRG_CTRL_IDX[5:0], 2'b00};
  localparam logic [7:0] SBRG_CTRL_RESET = 8'h00;
  localparam logic [7:0] SBRG_CTRL_MASK = 8'h37;
  localparam int SBRG_PRE_LSB = 4;
  localparam int SBRG_RATE_LSB = 0;

  // ----------------------------------------------------------------
  // Divider chain divisors and terminal counts (divisor minus one)
  // ----------------------------------------------------------------
  localparam int SBRG_FIXED_DIV = 64;
  localparam int SBRG_OVS_DIV = 16;
  localparam logic [1:0] SBRG_FIX_TERM = 2'(SBRG_FIXED_DIV / SBRG_OVS_DIV - 1);
  localparam logic [3:0] SBRG_OVS_TERM = 4'(SBRG_OVS_DIV - 1);
  localparam logic [3:0] SBRG_PD1_TERM = 4'h0;
  localparam logic [3:0] SBRG_PD3_TERM = 4'h2;
  localparam logic [3:0] SBRG_PD4_TERM = 4'h3;
  localparam logic [3:0] SBRG_PD13_TERM = 4'hC;
  localparam logic [3:0] SBRG_PD_RESET = SBRG_PD1_TERM;
  localparam logic [6:0] SBRG_BD_RESET = 7'h00;

endpackage

// ===== logic/sbrg_modcnt.sv
// Modulo counter stage of the baud divider chain.
// Assumes term_i stays stable while counting; clr_i restarts the stage.
`timescale 1ns/1ns
module sbrg_modcnt
  import sbrg_pkg::*;
#(
  parameter int W = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  input wire logic en_i,
  input wire logic [W-1:0] term_i,
  output logic wrap_o
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // Wrap on reaching term; >= keeps a lowered term from stranding the count
  assign wrap_o = en_i && (cnt_q >= term_i);

  // Next count
  always_comb begin
    cnt_d = cnt_q;
    if (clr_i) begin
      cnt_d = '0;
    end else if (wrap_o) begin
      cnt_d = '0;
    end else if (en_i) begin
      cnt_d = cnt_q + W'(1);
    end
  end

  // Count register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule // sbrg_modcnt

// ===== logic/sbrg_divsel.sv
// Decoder from the control fields to terminal counts of the divider stages.
// Assumes the select fields come from the control register, same clock.
`timescale 1ns/1ns
module sbrg_divsel
  import sbrg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] pre_sel_i,
  input wire logic [2:0] rate_sel_i,
  output logic [3:0] pd_term_o,
  output logic [6:0] bd_term_o
);

  logic [3:0] pd_d;
  logic [6:0] bd_d;

  // Prescale divisor 1/3/4/13, rate divisor a power of two
  always_comb begin
    unique case (pre_sel_i)
      2'b00: pd_d = SBRG_PD1_TERM;
      2'b01: pd_d = SBRG_PD3_TERM;
      2'b10: pd_d = SBRG_PD4_TERM;
      2'b11: pd_d = SBRG_PD13_TERM;
    endcase
    bd_d = 7'((8'h01 << rate_sel_i) - 8'h01);
  end

  // Registered so the decode never sits in the counter compare path
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pd_term_o <= SBRG_PD_RESET;
      bd_term_o <= SBRG_BD_RESET;
    end else begin
      pd_term_o <= pd_d;
      bd_term_o <= bd_d;
    end
  end

endmodule // sbrg_divsel

// ===== logic/sbrg_top.sv
// Serial baud rate generator: APB control register and divider chain.
// Assumes MCLK_I is the crystal clock and the shift logic uses the ticks.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns
module sbrg_top
  import sbrg_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic RX_SAMPLE_TICK_O,
  output logic TX_BIT_TICK_O
);

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic hit;
  logic take;
  logic wr_take;

  assign hit = (PADDR_I == SBRG_CTRL_ADDR);
  // Transfer completes on the edge where pready is seen high
  assign take = PSEL_I && PENABLE_I && pready_q;
  assign wr_take = take && PWRITE_I && hit;

  // One wait state: pready rises one cycle into the access phase
  always_comb begin
    pready_d = PSEL_I && PENABLE_I && !pready_q;
    pslverr_d = PSEL_I && PENABLE_I && !pready_q && !hit;
    prdata_d = prdata_q;
    if (PSEL_I && PENABLE_I && !pready_q) begin
      prdata_d = (hit && !PWRITE_I) ? {24'h000000, ctrl_q} : 32'h00000000;
    end
    ctrl_d = ctrl_q;
    if (wr_take) begin
      ctrl_d = PWDATA_I[7:0] & SBRG_CTRL_MASK;
    end
  end

  // Bus and control registers; reserved bits held at zero
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      ctrl_q <= SBRG_CTRL_RESET;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      ctrl_q <= ctrl_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  assign PREADY_O = pready_q;
  assign PSLVERR_O = pslverr_q;
  assign PRDATA_O = prdata_q;

  // ----------------------------------------------------------------
  // Divider chain
  // ----------------------------------------------------------------
  logic [3:0] pd_term;
  logic [6:0] bd_term;
  logic fix_wrap;
  logic pd_wrap;
  logic bd_wrap;
  logic ovs_wrap;
  logic rx_tick_q;
  logic rx_tick_d;
  logic tx_tick_q;
  logic tx_tick_d;

  // Field decode to terminal counts
  sbrg_divsel u_divsel (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .pre_sel_i(ctrl_q[SBRG_PRE_LSB +: 2]),
    .rate_sel_i(ctrl_q[SBRG_RATE_LSB +: 3]),
    .pd_term_o(pd_term),
    .bd_term_o(bd_term)
  );

  // Fixed divide by 4; with the 16x stage this makes the fixed 64
  sbrg_modcnt #(.W(2)) u_fix (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .clr_i(wr_take),
    .en_i(1'b1),
    .term_i(SBRG_FIX_TERM),
    .wrap_o(fix_wrap)
  );

  // Prescale divisor stage
  sbrg_modcnt #(.W(4)) u_pd (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .clr_i(wr_take),
    .en_i(fix_wrap),
    .term_i(pd_term),
    .wrap_o(pd_wrap)
  );

  // Rate divisor stage
  sbrg_modcnt #(.W(7)) u_bd (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .clr_i(wr_take),
    .en_i(pd_wrap),
    .term_i(bd_term),
    .wrap_o(bd_wrap)
  );

  // Oversampling stage, 16 receive ticks to one bit time
  sbrg_modcnt #(.W(4)) u_ovs (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .clr_i(wr_take),
    .en_i(bd_wrap),
    .term_i(SBRG_OVS_TERM),
    .wrap_o(ovs_wrap)
  );

  // Both ticks come from one chain, so rx and tx share one rate
  always_comb begin
    rx_tick_d = bd_wrap;
    tx_tick_d = ovs_wrap;
  end

  // Tick outputs registered; a write restarts the chain cleanly
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      rx_tick_q <= 1'b0;
      tx_tick_q <= 1'b0;
    end else begin
      rx_tick_q <= rx_tick_d;
      tx_tick_q <= tx_tick_d;
    end
  end

  assign RX_SAMPLE_TICK_O = rx_tick_q;
  assign TX_BIT_TICK_O = tx_tick_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [12:0] gap_q;
  logic gap_ok_q;
  logic [4:0] rxn_q;
  logic rxn_ok_q;

  // Independent reference for the prescale divisor, used for the rx tick period
  function automatic int exp_pd(input logic [1:0] s);
    int r;
    r = 1;
    unique case (s)
      2'b00: r = 1;
      2'b01: r = 3;
      2'b10: r = 4;
      2'b11: r = 13;
    endcase
    return r;
  endfunction

  // Gap between rx ticks, rx ticks between tx ticks; reset by writes
  always_ff @(posedge MCLK_I) begin
    if (RST_I || wr_take) begin
      gap_q <= 13'h0000;
      gap_ok_q <= 1'b0;
      rxn_q <= 5'h00;
      rxn_ok_q <= 1'b0;
    end else begin
      gap_q <= rx_tick_q ? 13'h0000 : gap_q + 13'h0001;
      gap_ok_q <= gap_ok_q || rx_tick_q;
      if (tx_tick_q) begin
        rxn_q <= 5'h00;
        rxn_ok_q <= 1'b1;
      end else if (rx_tick_q) begin
        rxn_q <= rxn_q + 5'h01;
      end
    end
  end

  property p_tx_in_rx;
    @(posedge MCLK_I) disable iff (RST_I)
      TX_BIT_TICK_O |-> RX_SAMPLE_TICK_O;
  endproperty
  a_tx_in_rx: assert property (p_tx_in_rx)
    else $error("tx tick without rx tick");

  property p_pd_decode;
    @(posedge MCLK_I) disable iff (RST_I)
      $stable(ctrl_q) |-> (32'(pd_term) + 1 == exp_pd(ctrl_q[5:4]));
  endproperty
  a_pd_decode: assert property (p_pd_decode)
    else $error("prescale divisor decode wrong");

  property p_bd_decode;
    @(posedge MCLK_I) disable iff (RST_I)
      $stable(ctrl_q) |-> (32'(bd_term) + 1 == (1 << ctrl_q[2:0]));
  endproperty
  a_bd_decode: assert property (p_bd_decode)
    else $error("rate divisor decode wrong");

  property p_rx_period;
    @(posedge MCLK_I) disable iff (RST_I)
      (RX_SAMPLE_TICK_O && gap_ok_q) |->
        (32'(gap_q) + 1 == 4 * exp_pd(ctrl_q[5:4]) * (1 << ctrl_q[2:0]));
  endproperty
  a_rx_period: assert property (p_rx_period)
    else $error("rx tick period does not match divisors");

  property p_reset_clear;
    @(posedge MCLK_I) disable iff (RST_I)
      $fell(RST_I) |-> (ctrl_q == 8'h00) ##2 (ctrl_q == 8'h00 || $past(wr_take));
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("control not cleared by reset");

  property p_write_read;
    @(posedge MCLK_I) disable iff (RST_I)
      wr_take |=> (ctrl_q == ($past(PWDATA_I[7:0]) & 8'h37));
  endproperty
  a_write_read: assert property (p_write_read)
    else $error("written fields not held");

  property p_sixteen;
    @(posedge MCLK_I) disable iff (RST_I)
      (TX_BIT_TICK_O && rxn_ok_q) |-> (rxn_q == 5'h0F);
  endproperty
  a_sixteen: assert property (p_sixteen)
    else $error("tx tick not every sixteenth rx tick");

  // Bus side: one wait state, one-cycle answer, refused places left alone
  property p_one_wait;
    @(posedge MCLK_I) disable iff (RST_I)
      (PSEL_I && $rose(PENABLE_I)) |=> PREADY_O;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("ready not one cycle into the access phase");

  property p_ready_pulse;
    @(posedge MCLK_I) disable iff (RST_I)
      PREADY_O |=> !PREADY_O;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready held longer than one cycle");

  property p_read_field;
    @(posedge MCLK_I) disable iff (RST_I)
      (take && !PWRITE_I && hit) |-> (PRDATA_O == {24'h000000, ctrl_q});
  endproperty
  a_read_field: assert property (p_read_field)
    else $error("read data differs from control fields");

  property p_refused;
    @(posedge MCLK_I) disable iff (RST_I)
      (take && !hit) |-> (PSLVERR_O && PRDATA_O == 32'h00000000) ##1 $stable(ctrl_q);
  endproperty
  a_refused: assert property (p_refused)
    else $error("unmapped access not refused");

  // Reserved bits can never hold a one, whatever software writes
  property p_reserved;
    @(posedge MCLK_I) disable iff (RST_I)
      (ctrl_q & ~SBRG_CTRL_MASK) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved control bit set");

  // Shortest rx period is four cycles, so a tick never lasts two
  property p_rx_short;
    @(posedge MCLK_I) disable iff (RST_I)
      RX_SAMPLE_TICK_O |=> !RX_SAMPLE_TICK_O;
  endproperty
  a_rx_short: assert property (p_rx_short)
    else $error("rx tick longer than one cycle");

  cover property (@(posedge MCLK_I) disable iff (RST_I) wr_take);
  cover property (@(posedge MCLK_I) disable iff (RST_I) TX_BIT_TICK_O && rxn_ok_q);
  cover property (@(posedge MCLK_I) disable iff (RST_I)
    RX_SAMPLE_TICK_O && gap_ok_q && ctrl_q[5:4] == 2'b11);
  cover property (@(posedge MCLK_I) disable iff (RST_I) PSLVERR_O);

endmodule // sbrg_top

// ===== verification/sbrg_shift_model.sv
// Model of the shift logic that consumes the two baud ticks.
// Assumes both ticks are one-cycle pulses on the crystal clock.
`timescale 1ns/1ns
module sbrg_shift_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rx_tick_i,
  input wire logic tx_tick_i,
  output logic [7:0] rx_per_bit_o,
  output logic [15:0] rx_gap_o
);
  logic [7:0] rx_cnt_q;
  logic [15:0] gap_q;
  // Oversample ticks per bit time, and spacing of the oversample ticks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_cnt_q <= 8'h00;
      gap_q <= 16'h0000;
      rx_per_bit_o <= 8'h00;
      rx_gap_o <= 16'h0000;
    end else begin
      gap_q <= rx_tick_i ? 16'h0001 : gap_q + 16'h0001;
      if (rx_tick_i) begin
        rx_gap_o <= gap_q;
      end
      // Receiver and transmitter share one rate: 16 samples a bit
      if (tx_tick_i) begin
        rx_per_bit_o <= rx_cnt_q + 8'(rx_tick_i);
        rx_cnt_q <= 8'h00;
      end else begin
        rx_cnt_q <= rx_cnt_q + 8'(rx_tick_i);
      end
    end
  end
endmodule // sbrg_shift_model

// ===== verification/tb_top.sv
// Self-checking bench: APB register access and tick spacing.
// Assumes the design answers APB with its own wait state.
`timescale 1ns/1ns
module tb_top;
  localparam logic [7:0] CTRL = sbrg_pkg::SBRG_CTRL_ADDR;
  logic clk, rst, psel, pen, pwr, err, pready, pslverr, rx_tick, tx_tick;
  logic [7:0] paddr, rx_per_bit;
  logic [15:0] rx_gap;
  logic [31:0] pwdata, rdata, prdata;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  int gap;
  int pd_tab [4] = '{1, 3, 4, 13};
  logic [7:0] codes [12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
                            8'h10, 8'h20, 8'h30, 8'h32};

  sbrg_top dut_u (.MCLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .RX_SAMPLE_TICK_O(rx_tick),
    .TX_BIT_TICK_O(tx_tick));
  sbrg_shift_model model_u (.clk_i(clk), .rst_i(rst), .rx_tick_i(rx_tick),
    .tx_tick_i(tx_tick), .rx_per_bit_o(rx_per_bit), .rx_gap_o(rx_gap));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    chk(32'(n), 32'd2);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  // Skip the restart interval, then count one full bit time
  task automatic tx_gap(output int g);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (tx_tick !== 1'b1 && n < 20000);
    g = 0;
    do begin
      @(posedge clk);
      g++;
    end while (tx_tick !== 1'b1 && g < 20000);
    @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Hang guard, well above the longest divider sweep
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      give_verdict();
    end
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, CTRL, 32'h0);
    chk(rdata, 32'h00);
    chk(32'(err), 32'h0);
    $display("reset test done");
    // Reserved bits read zero, fields keep what was written
    apb(1'b1, CTRL, 32'hFFFF_FFFF);
    apb(1'b0, CTRL, 32'h0);
    chk(rdata, 32'h37);
    // Unmapped place: refused, control untouched
    apb(1'b1, 8'h60, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b0, 8'h60, 32'h0);
    chk(rdata, 32'h0);
    apb(1'b0, CTRL, 32'h0);
    chk(rdata, 32'h37);
    // Reset in mid-run clears both fields again
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, CTRL, 32'h0);
    chk(rdata, 32'h00);
    chk(32'(err), 32'h0);
    $display("access test done");
    // Every prescale and rate code: bit time and sample spacing
    foreach (codes[i]) begin
      apb(1'b1, CTRL, 32'(codes[i]));
      apb(1'b0, CTRL, 32'h0);
      chk(rdata, 32'(codes[i]));
      tx_gap(gap);
      chk(gap, 64 * pd_tab[codes[i][5:4]] * (1 << codes[i][2:0]));
      chk(32'(rx_gap), 4 * pd_tab[codes[i][5:4]] * (1 << codes[i][2:0]));
      chk(32'(rx_per_bit), 32'd16);
    end
    $display("divider test done");
    give_verdict();
  end
endmodule // tb_top
